/* File: nssp_host.sv */
// host controller: axi4-lite registers driving nand status, id and locks
`timescale 1ns/100ps
// Functional notes
// - every operation but the wp pulse starts with its own fresh command, lock query after a ready wait
// - reserved status bits 4..2 are masked off and ignored
// - signature read: command 90h then one address cycle 00h
// - unlock: setup, three start bytes, confirm, three end bytes
// - start block must not exceed end block; equal unlocks one
// - lock-down release needs write protect low at least 100 ns
// - lock query: command, three address bytes, then read
module nssp_host (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic nand_ce_n,
	output logic nand_cle,
	output logic nand_ale,
	output logic nand_we_n,
	output logic nand_re_n,
	output logic nand_wp_n,
	output logic [7:0] nand_io_out,
	output logic nand_io_oe,
	input wire logic [7:0] nand_io_in,
	input wire logic ready_busy_output,
	output logic lock_mode_strap
);
	import nssp_pkg::*;

	typedef enum logic [1:0] {
		MS_IDLE = 2'b00,
		MS_ISSUE = 2'b01,
		MS_WAIT = 2'b10,
		MS_WPLOW = 2'b11
	} nssp_main_type;

	typedef struct packed {
		nssp_main_type state;
		nssp_op_type op;
		logic [3:0] idx;
		logic [1:0] rcnt;
		logic [4:0] cnt;
		logic cyc_start;
		logic [23:0] start_blk;
		logic [23:0] end_blk;
		logic strap;
		logic wp_perm;
		logic err;
		logic [7:0] stat;
		logic [2:0] lock;
		logic [31:0] sig;
		logic rb_s1;
		logic rb_s2;
		logic aw_have;
		logic [7:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} nssp_host_state_type;

	nssp_host_state_type host_reg;
	nssp_host_state_type host_next;
	logic cyc_done;
	logic [7:0] cyc_rdata;
	logic [10:0] cur_step;
	nssp_kind_type cur_kind;

	function automatic logic [7:0] byte_of(input logic [23:0] v,
		input logic [1:0] k);
		logic [7:0] b;
		b = v[7:0];
		if (k == 2'h1)
			b = v[15:8];
		else if (k == 2'h2)
			b = v[23:16];
		return b;
	endfunction : byte_of

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				m[8*i +: 8] = val[8*i +: 8];
		end
		return m;
	endfunction : merge

	// {valid, kind, byte}; address bytes go least significant first
	function automatic logic [10:0] step_of(input nssp_op_type op,
		input logic [3:0] i, input logic [23:0] sb, input logic [23:0] eb);
		logic [10:0] s;
		s = 11'h000;
		case (op)
			OP_STATUS: begin
				if (i == 4'h0)
					s = {1'b1, KIND_CMD, CMD_READ_STATUS};
				else if (i == 4'h1)
					s = {1'b1, KIND_READ, 8'h00};
			end
			OP_SIGNATURE: begin
				if (i == 4'h0)
					s = {1'b1, KIND_CMD, CMD_SIGNATURE};
				else if (i == 4'h1)
					s = {1'b1, KIND_ADDR, SIG_ADDR};
				else if (i <= 4'h5)
					s = {1'b1, KIND_READ, 8'h00};
			end
			OP_LOCK_ALL: begin
				if (i == 4'h0)
					s = {1'b1, KIND_CMD, CMD_LOCK_ALL};
			end
			OP_UNLOCK: begin
				if (i == 4'h0)
					s = {1'b1, KIND_CMD, CMD_UNLOCK_SETUP};
				else if (i <= 4'h3)
					s = {1'b1, KIND_ADDR, byte_of(sb, 2'(i - 4'h1))};
				else if (i == 4'h4)
					s = {1'b1, KIND_CMD, CMD_UNLOCK_CONFIRM};
				else if (i <= 4'h7)
					s = {1'b1, KIND_ADDR, byte_of(eb, 2'(i - 4'h5))};
			end
			OP_LOCK_DOWN: begin
				if (i == 4'h0)
					s = {1'b1, KIND_CMD, CMD_LOCK_DOWN};
			end
			OP_LOCK_QUERY: begin
				if (i == 4'h0)
					s = {1'b1, KIND_WAIT, 8'h00};
				else if (i == 4'h1)
					s = {1'b1, KIND_CMD, CMD_LOCK_QUERY};
				else if (i <= 4'h4)
					s = {1'b1, KIND_ADDR, byte_of(sb, 2'(i - 4'h2))};
				else if (i == 4'h5)
					s = {1'b1, KIND_READ, 8'h00};
			end
			default: s = 11'h000;
		endcase
		return s;
	endfunction : step_of

	assign cur_step = step_of(host_reg.op, host_reg.idx, host_reg.start_blk,
		host_reg.end_blk);
	assign cur_kind = nssp_kind_type'(cur_step[9:8]);

	always_comb begin
		logic go;
		nssp_op_type new_op;
		go = 1'b0;
		new_op = OP_STATUS;
		host_next = host_reg;
		host_next.cyc_start = 1'b0;
		host_next.rb_s1 = ready_busy_output;
		host_next.rb_s2 = host_reg.rb_s1;
		if (s_axi_awvalid && !host_reg.aw_have) begin
			host_next.aw_have = 1'b1;
			host_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !host_reg.w_have) begin
			host_next.w_have = 1'b1;
			host_next.wdata = s_axi_wdata;
			host_next.wstrb = s_axi_wstrb;
		end
		if (host_reg.bvalid && s_axi_bready)
			host_next.bvalid = 1'b0;
		if (host_reg.aw_have && host_reg.w_have && !host_reg.bvalid) begin
			host_next.aw_have = 1'b0;
			host_next.w_have = 1'b0;
			host_next.bvalid = 1'b1;
			host_next.bresp = RESP_OKAY;
			unique case (host_reg.awaddr)
				REG_CTRL: begin
					if (host_reg.wstrb[1]) begin
						host_next.strap = host_reg.wdata[CTRL_STRAP_BIT];
						host_next.wp_perm = host_reg.wdata[CTRL_WP_BIT];
					end
					if (host_reg.wstrb[0] && host_reg.wdata[CTRL_GO_BIT]) begin
						go = 1'b1;
						new_op = nssp_op_type'(host_reg.wdata[CTRL_OP_LSB +: 3]);
					end
				end
				REG_START: host_next.start_blk = 24'(merge({8'h00,
					host_reg.start_blk}, host_reg.wdata, host_reg.wstrb));
				REG_END: host_next.end_blk = 24'(merge({8'h00,
					host_reg.end_blk}, host_reg.wdata, host_reg.wstrb));
				REG_STATUS, REG_SIG: host_next.bresp = RESP_OKAY;
				default: host_next.bresp = RESP_SLVERR;
			endcase
		end
		if (host_reg.rvalid && s_axi_rready)
			host_next.rvalid = 1'b0;
		if (s_axi_arvalid && !host_reg.rvalid) begin
			host_next.rvalid = 1'b1;
			host_next.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				REG_CTRL: host_next.rdata = {22'h000000, host_reg.wp_perm,
					host_reg.strap, 4'h0, host_reg.op, 1'b0};
				REG_START: host_next.rdata = {8'h00, host_reg.start_blk};
				REG_END: host_next.rdata = {8'h00, host_reg.end_blk};
				REG_STATUS: host_next.rdata = {13'h0000, host_reg.lock,
					host_reg.stat, 5'h00, host_reg.rb_s2, host_reg.err,
					host_reg.state != MS_IDLE};
				REG_SIG: host_next.rdata = host_reg.sig;
				default: begin
					host_next.rdata = 32'h00000000;
					host_next.rresp = RESP_SLVERR;
				end
			endcase
		end
		unique case (host_reg.state)
			MS_IDLE: begin
				// a start while busy is dropped; software polls busy first
				if (go) begin
					host_next.op = new_op;
					host_next.idx = 4'h0;
					host_next.rcnt = 2'h0;
					host_next.err = 1'b0;
					if (host_reg.wdata[CTRL_OP_LSB +: 3] == 3'h7) begin
						host_next.err = 1'b1;
					end else if (new_op == OP_UNLOCK &&
						host_reg.start_blk > host_reg.end_blk) begin
						host_next.err = 1'b1;
					end else if ((new_op == OP_LOCK_ALL || new_op == OP_UNLOCK ||
						new_op == OP_LOCK_DOWN || new_op == OP_LOCK_QUERY) &&
						!host_next.strap) begin
						host_next.err = 1'b1;
					end else if (new_op == OP_WP_PULSE) begin
						host_next.state = MS_WPLOW;
						host_next.cnt = WPLOW_CYC - 5'h01;
					end else begin
						host_next.state = MS_ISSUE;
					end
				end
			end
			MS_ISSUE: begin
				if (!cur_step[10]) begin
					host_next.state = MS_IDLE;
				end else if (cur_kind == KIND_WAIT) begin
					if (host_reg.rb_s2)
						host_next.idx = host_reg.idx + 4'h1;
				end else begin
					host_next.cyc_start = 1'b1;
					host_next.state = MS_WAIT;
				end
			end
			MS_WAIT: begin
				if (cyc_done) begin
					host_next.idx = host_reg.idx + 4'h1;
					host_next.state = MS_ISSUE;
					if (cur_kind == KIND_READ) begin
						host_next.rcnt = host_reg.rcnt + 2'h1;
						if (host_reg.op == OP_STATUS)
							host_next.stat = cyc_rdata & STATUS_KEEP_MASK;
						if (host_reg.op == OP_SIGNATURE)
							host_next.sig[{host_reg.rcnt, 3'b000} +: 8] =
								cyc_rdata;
						if (host_reg.op == OP_LOCK_QUERY)
							host_next.lock = cyc_rdata[2:0];
					end
				end
			end
			MS_WPLOW: begin
				if (host_reg.cnt == 5'h00)
					host_next.state = MS_IDLE;
				else
					host_next.cnt = host_reg.cnt - 5'h01;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_reg <= '0;
			host_reg.strap <= CTRL_STRAP_RESET;
			host_reg.wp_perm <= CTRL_WP_RESET;
		end else if (ce) begin
			host_reg <= host_next;
		end
	end

	nssp_cycle nssp_cycle_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.start(host_reg.cyc_start),
		.kind(cur_kind),
		.wdata(cur_step[7:0]),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.cle(nand_cle),
		.ale(nand_ale),
		.we_n(nand_we_n),
		.re_n(nand_re_n),
		.io_out(nand_io_out),
		.io_oe(nand_io_oe),
		.io_in(nand_io_in)
	);

	assign s_axi_awready = !host_reg.aw_have;
	assign s_axi_wready = !host_reg.w_have;
	assign s_axi_bvalid = host_reg.bvalid;
	assign s_axi_bresp = host_reg.bresp;
	assign s_axi_arready = !host_reg.rvalid;
	assign s_axi_rvalid = host_reg.rvalid;
	assign s_axi_rdata = host_reg.rdata;
	assign s_axi_rresp = host_reg.rresp;
	// chip stays selected for the whole operation, reads included
	assign nand_ce_n = (host_reg.state == MS_IDLE);
	assign nand_wp_n = host_reg.wp_perm && (host_reg.state != MS_WPLOW);
	assign lock_mode_strap = host_reg.strap;

	sequence s_wp_low13;
		(!nand_wp_n) [*8] ##1 (!nand_wp_n) [*5];
	endsequence
	sequence s_sig_addr;
		##[1:40] (nand_ale && !nand_we_n && nand_io_out == SIG_ADDR);
	endsequence

	a_wp_pulse_len: assert property (@(posedge aclk)
		disable iff (!aresetn) (ce && $fell(nand_wp_n)) |-> s_wp_low13)
		else $error("write protect pulse shorter than 100 ns");
	a_sig_cmd_addr: assert property (@(posedge aclk)
		disable iff (!aresetn) ($fell(nand_we_n) && nand_cle &&
		nand_io_out == CMD_SIGNATURE && ce) |-> s_sig_addr)
		else $error("signature command not followed by address 00");
	a_query_ready: assert property (@(posedge aclk)
		disable iff (!aresetn) ($fell(nand_we_n) && nand_cle &&
		nand_io_out == CMD_LOCK_QUERY) |-> $past(host_reg.rb_s2, 4))
		else $error("lock query issued while device busy");
	a_lock_strap: assert property (@(posedge aclk)
		disable iff (!aresetn) (nand_cle && !nand_we_n &&
		(nand_io_out == CMD_LOCK_ALL || nand_io_out == CMD_LOCK_DOWN ||
		nand_io_out == CMD_UNLOCK_SETUP)) |-> lock_mode_strap)
		else $error("lock command with strap low");
	a_range_order: assert property (@(posedge aclk)
		disable iff (!aresetn) (ce && host_reg.state == MS_ISSUE &&
		host_reg.op == OP_UNLOCK) |-> host_reg.start_blk <= host_reg.end_blk)
		else $error("unlock started with reversed range");
	a_stat_mask: assert property (@(posedge aclk)
		disable iff (!aresetn) (host_reg.stat & ~STATUS_KEEP_MASK) == 8'h00)
		else $error("reserved status bits captured");
	a_read_selected: assert property (@(posedge aclk)
		disable iff (!aresetn) !nand_re_n |-> !nand_ce_n && !nand_io_oe)
		else $error("read strobe without chip enable");
	a_lock_capture: assert property (@(posedge aclk)
		disable iff (!aresetn) (ce && host_reg.state == MS_WAIT && cyc_done &&
		host_reg.op == OP_LOCK_QUERY && cur_kind == KIND_READ)
		|=> host_reg.lock == $past(cyc_rdata[2:0]))
		else $error("lock state not captured");
	a_unlock_len: assert property (@(posedge aclk)
		disable iff (!aresetn) (ce && host_reg.state == MS_ISSUE &&
		host_reg.op == OP_UNLOCK && !cur_step[10]) |-> host_reg.idx == 4'h8)
		else $error("unlock sequence has wrong cycle count");
endmodule : nssp_host

/* File: nssp_pkg.sv */
// shared constants and types for the nand protection host controller
package nssp_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_STROBE_NS = 25;
	localparam int T_HOLD_NS = 15;
	localparam int T_REA_NS = 30;
	localparam int T_WPLOW_NS = 100;
	localparam int SYNC_DEPTH = 2;
	localparam logic [4:0] STROBE_CYC =
		5'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] HOLD_CYC =
		5'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] READ_LOW_CYC =
		5'((T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_DEPTH + 1);
	localparam logic [4:0] WPLOW_CYC =
		5'((T_WPLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_SIGNATURE = 8'h90;
	localparam logic [7:0] SIG_ADDR = 8'h00;
	localparam logic [7:0] CMD_LOCK_ALL = 8'h2a;
	localparam logic [7:0] CMD_UNLOCK_SETUP = 8'h23;
	localparam logic [7:0] CMD_UNLOCK_CONFIRM = 8'h24;
	localparam logic [7:0] CMD_LOCK_DOWN = 8'h2c;
	localparam logic [7:0] CMD_LOCK_QUERY = 8'h7a;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_START = 8'h04;
	localparam logic [7:0] REG_END = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_SIG = 8'h10;
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_OP_LSB = 1;
	localparam int CTRL_STRAP_BIT = 8;
	localparam int CTRL_WP_BIT = 9;
	localparam logic CTRL_STRAP_RESET = 1'b0;
	localparam logic CTRL_WP_RESET = 1'b0;
	localparam logic [7:0] STATUS_KEEP_MASK = 8'he3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		KIND_CMD = 2'b00,
		KIND_ADDR = 2'b01,
		KIND_READ = 2'b10,
		KIND_WAIT = 2'b11
	} nssp_kind_type;

	typedef enum logic [2:0] {
		OP_STATUS = 3'b000,
		OP_SIGNATURE = 3'b001,
		OP_LOCK_ALL = 3'b010,
		OP_UNLOCK = 3'b011,
		OP_LOCK_DOWN = 3'b100,
		OP_LOCK_QUERY = 3'b101,
		OP_WP_PULSE = 3'b110
	} nssp_op_type;
endpackage : nssp_pkg

/* File: nssp_cycle.sv */
// one nand bus cycle: command latch, address latch or data read
`timescale 1ns/100ps
module nssp_cycle (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic start,
	input wire nssp_pkg::nssp_kind_type kind,
	input wire logic [7:0] wdata,
	output logic done,
	output logic [7:0] rdata,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic re_n,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic [7:0] io_in
);
	import nssp_pkg::*;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_SETUP = 2'b01,
		PH_LOW = 2'b10,
		PH_HIGH = 2'b11
	} nssp_phase_type;

	typedef struct packed {
		nssp_phase_type phase;
		logic [4:0] cnt;
		nssp_kind_type kind;
		logic [7:0] data;
		logic [7:0] io_s1;
		logic [7:0] io_s2;
		logic [7:0] rdata;
		logic done;
	} nssp_cycle_state_type;

	nssp_cycle_state_type cyc_reg;
	nssp_cycle_state_type cyc_next;

	always_comb begin
		cyc_next = cyc_reg;
		cyc_next.done = 1'b0;
		cyc_next.io_s1 = io_in;
		cyc_next.io_s2 = cyc_reg.io_s1;
		unique case (cyc_reg.phase)
			PH_IDLE: begin
				if (start) begin
					cyc_next.phase = PH_SETUP;
					cyc_next.kind = kind;
					cyc_next.data = wdata;
				end
			end
			PH_SETUP: begin
				cyc_next.phase = PH_LOW;
				// reads stay low long enough to cover the pin synchroniser
				cyc_next.cnt = (cyc_reg.kind == KIND_READ) ?
					READ_LOW_CYC - 5'h01 : STROBE_CYC - 5'h01;
			end
			PH_LOW: begin
				if (cyc_reg.cnt == 5'h00) begin
					cyc_next.phase = PH_HIGH;
					cyc_next.cnt = HOLD_CYC - 5'h01;
					if (cyc_reg.kind == KIND_READ)
						cyc_next.rdata = cyc_reg.io_s2;
				end else begin
					cyc_next.cnt = cyc_reg.cnt - 5'h01;
				end
			end
			PH_HIGH: begin
				if (cyc_reg.cnt == 5'h00) begin
					cyc_next.phase = PH_IDLE;
					cyc_next.done = 1'b1;
				end else begin
					cyc_next.cnt = cyc_reg.cnt - 5'h01;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_reg <= '0;
		end else if (ce) begin
			cyc_reg <= cyc_next;
		end
	end

	assign cle = (cyc_reg.phase != PH_IDLE) && (cyc_reg.kind == KIND_CMD);
	assign ale = (cyc_reg.phase != PH_IDLE) && (cyc_reg.kind == KIND_ADDR);
	assign we_n = !((cyc_reg.phase == PH_LOW) && (cyc_reg.kind != KIND_READ));
	assign re_n = !((cyc_reg.phase == PH_LOW) && (cyc_reg.kind == KIND_READ));
	assign io_oe = (cyc_reg.phase != PH_IDLE) && (cyc_reg.kind != KIND_READ);
	assign io_out = cyc_reg.data;
	assign done = cyc_reg.done;
	assign rdata = cyc_reg.rdata;

	a_cle_ale_excl: assert property (@(posedge aclk) disable iff (!aresetn)
		!(cle && ale)) else $error("cle and ale high together");
endmodule : nssp_cycle

/* File: nssp_nand_model.sv */
// behavioural nand device: status byte, signature and block locks
`timescale 1ns/100ps
module nssp_nand_model #(
	parameter logic [31:0] SIG = 32'h42113c5a // arbitrary id bytes
) (
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire logic strap,
	input wire logic hold_busy,
	input wire logic [4:0] knobs, // engine rdy, cache, cache rdy, fails
	input wire logic [7:0] io_wr,
	output logic [7:0] io_rd,
	output logic rb
);
	import nssp_pkg::*;
	logic [7:0] cmd = 8'hff;
	logic [7:0] last = 8'h00;
	logic [7:0] dout;
	logic [7:0] stat;
	logic [23:0] abuf = 24'h0;
	logic [23:0] st = 24'h0;
	logic [23:0] lo = 24'h0;
	logic [23:0] hi = 24'h0;
	logic [23:0] qblk = 24'h0;
	logic [1:0] acnt = 2'd0;
	logic [1:0] idx = 2'd0;
	logic ranged = 1'b0;
	logic ld = 1'b0;
	logic is_lock;
	logic in_rng;
	realtime wp_fall = 0.0;

	assign rb = !hold_busy;
	assign in_rng = ranged && qblk >= lo && qblk <= hi;
	// reserved bits 4 and 2 left set so that host masking is visible
	assign stat = {wp_n,
		knobs[3] ? knobs[2] : knobs[4],
		knobs[4], 3'b101, knobs[1:0]};

	always_comb begin
		case (cmd)
			CMD_READ_STATUS: dout = stat;
			CMD_SIGNATURE: dout = SIG[8 * idx +: 8];
			CMD_LOCK_QUERY: dout = {5'b10110, in_rng, !ld, ld};
			default: dout = 8'h00;
		endcase
	end

	// a released bus shows the inverse, never a stale copy
	assign io_rd = (!ce_n && !re_n) ? dout : ~last;

	always @(posedge re_n) begin
		if (!ce_n) begin
			last = dout;
			if (cmd == CMD_SIGNATURE) idx = idx + 2'd1;
		end
	end

	always @(posedge we_n) begin
		if (!ce_n && cle) begin
			is_lock = io_wr inside {CMD_LOCK_ALL, CMD_UNLOCK_SETUP,
				CMD_UNLOCK_CONFIRM, CMD_LOCK_DOWN, CMD_LOCK_QUERY};
			if ((strap || !is_lock) &&
				!(io_wr == CMD_LOCK_QUERY && hold_busy)) begin
				if (io_wr == CMD_LOCK_ALL) ranged = 1'b0;
				if (io_wr == CMD_LOCK_DOWN) ld = 1'b1;
				st = abuf;
				cmd = io_wr;
				acnt = 2'd0;
				idx = 2'd0;
			end
		end else if (!ce_n && ale) begin
			abuf[8 * acnt +: 8] = io_wr;
			if (acnt == 2'd2 && cmd == CMD_UNLOCK_CONFIRM && !ld) begin
				lo = st;
				hi = abuf;
				ranged = 1'b1;
			end
			if (acnt == 2'd2 && cmd == CMD_LOCK_QUERY) qblk = abuf;
			if (cmd == CMD_SIGNATURE) idx = 2'd0;
			acnt = acnt + 2'd1;
		end
	end

	always @(negedge wp_n) wp_fall = $realtime;
	// lock-down clears only after a long enough low on write protect
	always @(posedge wp_n) begin
		if ($realtime - wp_fall >= 100.0) ld = 1'b0;
	end
endmodule : nssp_nand_model

/* File: nssp_host_tb.sv */
// self-checking bench: axi4-lite driven status, id and lock sequences
`timescale 1ns/100ps
module nssp_host_tb;
	import nssp_pkg::*;
	localparam logic [31:0] SIG_WORD = 32'h42113c5a; // arbitrary id bytes
	localparam logic [23:0] SCASES = {6'b110000, 6'b000101, 6'b101110,
		6'b011001};
	localparam logic [383:0] LSEQ = {24'h200000, 24'h505002, 24'h303030,
		24'h503006, 24'h504002, 24'h306090, 24'h503002, 24'h509006,
		24'h400000, 24'h509005, 24'h502001, 24'h302020, 24'h502001,
		24'h600000, 24'h502002, 24'h509006};
	localparam logic [71:0] RSEQ = {24'h200000, 24'h308071, 24'h700001};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic hold_busy = 1'b0;
	logic [4:0] knobs = 5'b10100;
	logic strap_on = 1'b0;
	logic wp_on = 1'b0;
	logic [3:0] strb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, ce_n, cle, ale, we_n;
	logic re_n, wp_n, io_oe, rb, strap;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, st;
	logic [7:0] io_out, io_dev, io_bus;
	int n_mismatch = 0;
	int checked = 0;
	int n_we = 0;

	assign io_bus = io_oe ? io_out : io_dev;
	always @(negedge we_n) n_we++;
	initial forever #4 aclk = ~aclk;

	nssp_host nssp_host_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .nand_ce_n(ce_n), .nand_cle(cle),
		.nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n), .nand_wp_n(wp_n),
		.nand_io_out(io_out), .nand_io_oe(io_oe), .nand_io_in(io_bus),
		.ready_busy_output(rb), .lock_mode_strap(strap));

	nssp_nand_model #(.SIG(SIG_WORD)) nssp_nand_model_inst (.ce_n(ce_n),
		.cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
		.strap(strap), .hold_busy(hold_busy), .knobs(knobs),
		.io_wr(io_bus), .io_rd(io_dev), .rb(rb));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ah;
		logic wh;
		logic bh;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n <= 100; n++) begin
			if (n == 100) begin
				n_mismatch++;
				print_verdict();
			end
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (bh) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ah;
		logic dh;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n <= 100; n++) begin
			if (n == 100) begin
				n_mismatch++;
				print_verdict();
			end
			@(negedge aclk);
			ah = arvalid && arready;
			dh = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'b0;
			if (dh) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd

	task automatic start_op(input logic [2:0] op, input logic [7:0] s,
		input logic [7:0] e);
		logic [1:0] r;
		wr(REG_START, {24'h0, s}, r);
		wr(REG_END, {24'h0, e}, r);
		wr(REG_CTRL, {22'h0, wp_on, strap_on, 4'h0, op, 1'b1}, r);
	endtask : start_op

	task automatic wait_op();
		logic [1:0] r;
		for (int n = 0; n <= 80; n++) begin
			if (n == 80) begin
				n_mismatch++;
				print_verdict();
			end
			rd(REG_STATUS, st, r);
			if (st[0] === 1'b0) break;
		end
	endtask : wait_op

	initial begin
		logic [1:0] r;
		logic [5:0] c;
		logic [23:0] t;
		logic [31:0] d;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(REG_CTRL, d, r);
		chk("ctrl after reset", d, 32'h0);
		rd(REG_STATUS, d, r);
		chk("status after reset", d, 32'h4);
		chk("wp pin after reset", wp_n, 1'b0);
		rd(8'h14, d, r);
		chk("unmapped rresp", r, RESP_SLVERR);
		chk("unmapped rdata", d, 32'h0);
		wr(8'h14, 32'h1, r);
		chk("unmapped bresp", r, RESP_SLVERR);
		wr(REG_SIG, 32'hffffffff, r);
		chk("read-only bresp", r, RESP_OKAY);
		strb <= 4'h2;
		wr(REG_START, 32'h0012ab34, r);
		strb <= 4'hf;
		rd(REG_START, d, r);
		chk("start byte lane", d, 32'h0000ab00);
		for (int i = 0; i < 4; i++) begin
			c = SCASES[23 - 6 * i -: 6];
			wp_on = c[5];
			knobs <= c[4:0];
			start_op(OP_STATUS, 8'h00, 8'h00);
			wait_op();
			chk("wp pin", wp_n, c[5]);
			chk("status byte", st[15:8], {c[5], (c[3] ? c[2] : c[4]), c[4], 3'b000, c[1:0]});
		end
		start_op(OP_SIGNATURE, 8'h00, 8'h00);
		wait_op();
		rd(REG_SIG, d, r);
		chk("signature", d, SIG_WORD);
		strap_on = 1'b1;
		wp_on = 1'b1;
		for (int i = 0; i < 16; i++) begin
			t = LSEQ[383 - 24 * i -: 24];
			start_op(t[22:20], t[19:12], t[11:4]);
			wait_op();
			chk("op error", st[1], 1'b0);
			if (t[22:20] == 3'd5) chk("lock state", st[18:16], t[2:0]);
		end
		hold_busy <= 1'b1;
		start_op(OP_LOCK_QUERY, 8'h09, 8'h00);
		repeat (40) @(posedge aclk);
		rd(REG_STATUS, d, r);
		@(negedge aclk);
		chk("query held", {d[0], cle, ale}, 3'b100);
		@(posedge aclk);
		ce <= 1'b0;
		hold_busy <= 1'b0;
		repeat (10) @(posedge aclk);
		@(negedge aclk);
		chk("frozen by ce", {cle, ce_n}, 2'b00);
		@(posedge aclk);
		ce <= 1'b1;
		wait_op();
		chk("query after busy", st[18:16], 3'b110);
		for (int i = 0; i < 3; i++) begin
			t = RSEQ[71 - 24 * i -: 24];
			strap_on = t[0];
			d = 32'(n_we);
			start_op(t[22:20], t[19:12], t[11:4]);
			wait_op();
			chk("refused error", st[1], 1'b1);
			chk("refused strobes", 32'(n_we), d);
		end
		strap_on = 1'b1;
		start_op(OP_LOCK_QUERY, 8'h09, 8'h00);
		wait_op();
		chk("range kept", st[18:16], 3'b110);
		print_verdict();
	end
endmodule : nssp_host_tb
